// [rtl/lrwp_pkg.sv]
// constants and types for the lcd ram write pointer
package lrwp_pkg;
   localparam int unsigned LRWP_COLS = 80;
   localparam int unsigned LRWP_ROWS = 4;
   localparam int unsigned LRWP_PTR_W = 7;
   localparam int unsigned LRWP_SUB_W = 3;
   localparam logic [6:0] LRWP_LAST_COL = 7'h4f;
   localparam logic [6:0] LRWP_PTR_RST = 7'h00;
   localparam logic [2:0] LRWP_SUB_RST = 3'h0;
   localparam logic [2:0] LRWP_BIT_LAST = 3'h7;
   // drive modes
   typedef enum logic [1:0] {
      LRWP_STATIC = 2'h0,
      LRWP_MUX2 = 2'h1,
      LRWP_MUX3 = 2'h2,
      LRWP_MUX4 = 2'h3
   } lrwp_mode_t;
   // pointer step per byte for each mode
   localparam logic [6:0] LRWP_STEP_STATIC = 7'h08;
   localparam logic [6:0] LRWP_STEP_MUX2 = 7'h04;
   localparam logic [6:0] LRWP_STEP_MUX3 = 7'h03;
   localparam logic [6:0] LRWP_STEP_MUX4 = 7'h02;
   // bits per column for each mode
   localparam logic [2:0] LRWP_BPC_STATIC = 3'h1;
   localparam logic [2:0] LRWP_BPC_MUX2 = 3'h2;
   localparam logic [2:0] LRWP_BPC_MUX3 = 3'h3;
   localparam logic [2:0] LRWP_BPC_MUX4 = 3'h4;
   // data path states, one-hot
   typedef enum logic [1:0] {
      LRWP_ST_IDLE = 2'b01,
      LRWP_ST_BYTE = 2'b10
   } lrwp_state_t;
endpackage

// [rtl/lrwp_top.sv]
// display ram write pointer, subaddress gate and bit-serial store
`timescale 1ns/1ps
`default_nettype none
module lrwp_top (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // drive mode and commands from the decoder
   input wire lrwp_pkg::lrwp_mode_t drive_mode,
   input wire logic ptr_load,
   input wire logic [6:0] ptr_value,
   input wire logic sub_load,
   input wire logic [2:0] sub_value,
   // hardware subaddress pins
   input wire logic subaddr_pin_bit0,
   input wire logic subaddr_pin_bit1,
   input wire logic subaddr_pin_bit2,
   // incoming display bits, msb first
   input wire logic bit_valid,
   output logic bit_ready,
   input wire logic bit_data,
   input wire logic byte_abort,
   // ram read port
   input wire logic [6:0] rd_col,
   output logic [3:0] rd_data,
   // state
   output logic [6:0] ptr_out,
   output logic [2:0] sub_out
);
   import lrwp_pkg::*;

   // reset release through two flops
   logic rst_s1_q, rst_n_q;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   // two-entry buffer: a stall downstream never drops a bit
   logic [1:0] buf_v_q;
   logic [1:0] buf_d_q;
   logic buf_rd_q;
   logic buf_wr_q;
   logic buf_out_v, buf_out_d, buf_pop, buf_push;
   logic buf_full_d;
   assign buf_push = bit_valid && bit_ready;
   // full after this edge: two held and none leaving, or one held plus one in
   assign buf_full_d = !buf_pop &&
      ((buf_v_q == 2'h3) || (buf_push && (buf_v_q != 2'h0)));
   assign buf_out_v = buf_v_q[buf_rd_q];
   assign buf_out_d = buf_d_q[buf_rd_q];
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         buf_v_q <= 2'h0;
         buf_d_q <= 2'h0;
         buf_rd_q <= 1'b0;
         buf_wr_q <= 1'b0;
         bit_ready <= 1'b0;
      end else begin
         if (buf_push) begin
            buf_v_q[buf_wr_q] <= 1'b1;
            buf_d_q[buf_wr_q] <= bit_data;
            buf_wr_q <= ~buf_wr_q;
         end
         if (buf_pop) begin
            buf_v_q[buf_rd_q] <= 1'b0;
            buf_rd_q <= ~buf_rd_q;
         end
         // ready registered from next fill, so a full buffer never takes one
         bit_ready <= !buf_full_d;
      end
   end

   // mode-dependent step and bits per column
   logic [6:0] step;
   logic [2:0] bpc;
   assign step = (drive_mode == LRWP_STATIC) ? LRWP_STEP_STATIC :
                 (drive_mode == LRWP_MUX2) ? LRWP_STEP_MUX2 :
                 (drive_mode == LRWP_MUX3) ? LRWP_STEP_MUX3 : LRWP_STEP_MUX4;
   assign bpc = (drive_mode == LRWP_STATIC) ? LRWP_BPC_STATIC :
                (drive_mode == LRWP_MUX2) ? LRWP_BPC_MUX2 :
                (drive_mode == LRWP_MUX3) ? LRWP_BPC_MUX3 : LRWP_BPC_MUX4;

   // per-bit position state
   lrwp_state_t st_q, st_d;
   logic [6:0] ptr_q, ptr_d, col_q, col_d;
   logic [2:0] sub_q, sub_d, bitn_q, bitn_d;
   logic [1:0] row_q, row_d;
   logic [2:0] hw_sub;
   logic match, store, last_row, col_wrap, last_bit, col_adv;
   logic [7:0] ptr_sum;
   logic [6:0] ptr_exp;
   logic [3:0] ram_q [LRWP_COLS];

   assign hw_sub = {subaddr_pin_bit2, subaddr_pin_bit1, subaddr_pin_bit0};
   assign match = (sub_q == hw_sub);
   // consume a bit only while not commanded this cycle
   assign buf_pop = buf_out_v && !ptr_load && !sub_load && !byte_abort;
   assign store = buf_pop && match;
   assign last_row = ({1'b0, row_q} == 3'(bpc - 3'h1));
   assign col_wrap = (col_q == LRWP_LAST_COL);
   assign last_bit = (bitn_q == LRWP_BIT_LAST);
   // in 1:3 the last bit of a byte also closes its column
   assign col_adv = last_row || last_bit;
   // pointer after a whole byte, wrapped, for the step check
   assign ptr_sum = {1'b0, ptr_q} + {1'b0, step};
   assign ptr_exp = (ptr_sum > {1'b0, LRWP_LAST_COL}) ?
                    7'(ptr_sum - 8'(LRWP_COLS)) : ptr_sum[6:0];

   // next state of pointer, column, row and subaddress
   always_comb begin
      st_d = st_q;
      ptr_d = ptr_q;
      col_d = col_q;
      row_d = row_q;
      bitn_d = bitn_q;
      sub_d = sub_q;
      case (st_q)
         LRWP_ST_IDLE: begin
            if (buf_pop) begin
               st_d = LRWP_ST_BYTE;
            end
         end
         LRWP_ST_BYTE: begin
            if (last_bit && buf_pop) begin
               st_d = LRWP_ST_IDLE;
            end
         end
         default: st_d = LRWP_ST_IDLE;
      endcase
      if (buf_pop) begin
         bitn_d = bitn_q + 3'h1;
         // row 2 of the third 1:3 column is skipped
         if (col_adv) begin
            row_d = 2'h0;
            if (col_wrap) begin
               col_d = 7'h00;
               sub_d = sub_q + 3'h1;
            end else begin
               col_d = col_q + 7'h01;
            end
         end else begin
            row_d = row_q + 2'h1;
         end
         // step pointer once the byte ends
         if (last_bit) begin
            ptr_d = col_d;
         end
      end
      // abort restarts at the pointer, value not guaranteed
      if (byte_abort) begin
         col_d = ptr_q;
         bitn_d = 3'h0;
         row_d = 2'h0;
         st_d = LRWP_ST_IDLE;
      end
      // load command sets pointer and column
      if (ptr_load) begin
         ptr_d = (ptr_value > LRWP_LAST_COL) ? LRWP_PTR_RST : ptr_value;
         col_d = ptr_d;
         row_d = 2'h0;
         bitn_d = 3'h0;
         st_d = LRWP_ST_IDLE;
      end
      if (sub_load) begin
         sub_d = sub_value;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         st_q <= LRWP_ST_IDLE;
         ptr_q <= LRWP_PTR_RST;
         col_q <= LRWP_PTR_RST;
         row_q <= 2'h0;
         bitn_q <= 3'h0;
         sub_q <= LRWP_SUB_RST;
      end else begin
         st_q <= st_d;
         ptr_q <= ptr_d;
         col_q <= col_d;
         row_q <= row_d;
         bitn_q <= bitn_d;
         sub_q <= sub_d;
      end
   end

   // 80 by 4 ram in flops; each bit written on arrival when the subaddress matches the pins
   // row fill per mode, unused rows kept
   genvar gc;
   generate
      for (gc = 0; gc < LRWP_COLS; gc++) begin : g_col
         always_ff @(posedge clk_sys or negedge rst_n_q) begin
            if (!rst_n_q) begin
               ram_q[gc] <= 4'h0;
            end else if (store && (col_q == 7'(gc))) begin
               ram_q[gc][row_q] <= buf_out_d;
            end
         end
      end
   endgenerate

   // registered outputs
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rd_data <= 4'h0;
         ptr_out <= LRWP_PTR_RST;
         sub_out <= LRWP_SUB_RST;
      end else begin
         rd_data <= (rd_col > LRWP_LAST_COL) ? 4'h0 : ram_q[rd_col];
         ptr_out <= ptr_d;
         sub_out <= sub_d;
      end
   end

   // checks
   // pointer step
   step_byte_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
      buf_pop && last_bit |=> ptr_q == $past(ptr_exp))
      else $error("pointer step wrong");
   gate_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
      buf_pop && !match |=> ram_q[$past(col_q)] == $past(ram_q[col_q]))
      else $error("write while subaddress differs");
   sub_inc_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
      buf_pop && col_adv && col_wrap && !sub_load
      |=> sub_q == $past(sub_q) + 3'h1)
      else $error("subaddress not bumped on overflow");
   col_wrap_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
      buf_pop && col_adv && col_wrap && !ptr_load |=> col_q == 7'h00)
      else $error("column did not wrap");
   sub_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
      sub_load |=> sub_q == $past(sub_value))
      else $error("subaddress not loaded");
   ptr_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
      ptr_load && ptr_value <= LRWP_LAST_COL |=> ptr_q == $past(ptr_value)
      ##0 col_q == ptr_q)
      else $error("pointer not loaded");
   bit_store_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
      store |=> ram_q[$past(col_q)][$past(row_q)] == $past(buf_out_d))
      else $error("bit not stored at once");
   skip_move_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
      buf_pop && !match && !last_row && !ptr_load && !byte_abort
      |=> row_q == ($past(last_bit) ? 2'h0 : $past(row_q) + 2'h1))
      else $error("skipped bit did not advance");
   cover_store_c: cover property (@(posedge clk_sys) store && last_bit);
   cover_wrap_c: cover property (@(posedge clk_sys)
      buf_pop && col_wrap && last_row && !last_bit);
   cover_skip_c: cover property (@(posedge clk_sys) buf_pop && !match);
   cover_stall_c: cover property (@(posedge clk_sys) bit_valid && !bit_ready);
endmodule
`default_nettype wire

// [verif/lrwp_host_bfm.sv]
// host model: command pulses and a bit stream into the block
`timescale 1ns/1ps
`default_nettype none
module lrwp_host_bfm (
   // clock and handshake
   input wire logic clk_sys,
   input wire logic bit_ready,
   // decoder side
   output logic ptr_load,
   output logic [6:0] ptr_value,
   output logic sub_load,
   output logic [2:0] sub_value,
   output logic bit_valid,
   output logic bit_data,
   output logic byte_abort
);
   initial begin
      {ptr_load, ptr_value, sub_load, sub_value} = '0;
      {bit_valid, bit_data, byte_abort} = '0;
   end
   // one-cycle command, value scrambled once the pulse is gone
   task automatic pulse(input int kind, input logic [6:0] v);
      @(posedge clk_sys) #1;
      ptr_load = (kind == 0);
      sub_load = (kind == 1);
      byte_abort = (kind == 2);
      ptr_value = v;
      sub_value = v[2:0];
      @(posedge clk_sys) #1;
      {ptr_load, sub_load, byte_abort} = '0;
      ptr_value = ~v;
      sub_value = ~v[2:0];
   endtask
   // bits only follow a load
   // msb first; random gaps so both prompt and slow delivery occur
   task automatic send(input logic [7:0] b, input int n);
      logic r;
      int g;
      for (int k = 0; k < n; k++) begin
         g = $urandom_range(0, 2);
         if (g > 0) begin
            bit_valid = 1'b0;
            bit_data = ~bit_data;
            repeat (g) @(posedge clk_sys) #1;
         end
         bit_valid = 1'b1;
         bit_data = b[7 - k];
         // ready is registered, so its negedge value is what the edge sees
         do begin
            @(negedge clk_sys) r = bit_ready;
            @(posedge clk_sys) #1;
         end while (!r);
      end
      bit_valid = 1'b0;
      bit_data = ~bit_data;
   endtask
endmodule
`default_nettype wire

// [verif/tb.sv]
// self-checking bench for the display ram write pointer
`timescale 1ns/1ps
`default_nettype none
module tb;
   import lrwp_pkg::*;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   lrwp_mode_t drive_mode = LRWP_MUX4;
   logic [2:0] pins = 3'h0;
   logic [6:0] rd_col = 7'h00;
   logic ptr_load, sub_load, bit_valid, bit_ready, bit_data, byte_abort;
   logic [6:0] ptr_value, ptr_out;
   logic [2:0] sub_value, sub_out, sub, p;
   logic [3:0] rd_data;
   logic [3:0] mem [80];
   int bad_count = 0;
   int compares = 0;
   int bstart;
   always #2.5 clk_sys = ~clk_sys;
   lrwp_top i_dut (.clk_sys, .nrst, .drive_mode, .ptr_load, .ptr_value,
      .sub_load, .sub_value, .subaddr_pin_bit0(pins[0]),
      .subaddr_pin_bit1(pins[1]), .subaddr_pin_bit2(pins[2]), .bit_valid,
      .bit_ready, .bit_data, .byte_abort, .rd_col, .rd_data, .ptr_out,
      .sub_out);
   lrwp_host_bfm i_host (.clk_sys, .bit_ready, .ptr_load, .ptr_value,
      .sub_load, .sub_value, .bit_valid, .bit_data, .byte_abort);
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // expected ram, pointer and counter after n bits of b
   task automatic model(input logic [7:0] b, input int n);
      int c;
      int bp;
      logic [2:0] s;
      bp = int'(drive_mode) + 1;
      for (int k = 0; k < n; k++) begin
         c = bstart + k / bp;
         s = (c >= 80) ? sub + 3'h1 : sub;
         if (s === pins) mem[c % 80][k % bp] = b[7 - k];
      end
      // step is whole columns a byte spans: 8, 4, 3, 2
      if (n == 8) begin
         bstart += (8 + bp - 1) / bp;
         if (bstart >= 80) sub += 3'h1;
         bstart %= 80;
      end
   endtask
   task automatic start(input int m, input logic [2:0] s,
                        input logic [6:0] v);
      drive_mode = lrwp_mode_t'(m);
      pins = p;
      i_host.pulse(1, {4'h0, s});
      i_host.pulse(0, v);
      sub = s;
      bstart = (v > 7'd79) ? 0 : int'(v);
      repeat (2) @(posedge clk_sys) #1;
      chk("sub_out", sub_out, s);
      chk("ptr_out", ptr_out, 8'(bstart));
   endtask
   task automatic tx(input int nbytes);
      logic [7:0] b;
      repeat (nbytes) begin
         b = 8'($urandom);
         i_host.send(b, 8);
         model(b, 8);
      end
   endtask
   task automatic settle_check();
      repeat (6) @(posedge clk_sys) #1;
      chk("ptr_out", ptr_out, 8'(bstart));
      chk("sub_out", sub_out, sub);
      for (int c = 0; c <= 80; c++) begin
         rd_col = 7'(c);
         @(posedge clk_sys) #1;
         chk("rd_data", rd_data, (c < 80) ? mem[c] : 4'h0);
      end
   endtask
   initial begin
      #200000;
      bad_count++;
      close_out();
   end
   initial begin
      logic [7:0] b;
      void'($urandom(255));
      repeat (2) @(posedge clk_sys) #1;
      chk("ptr_out", ptr_out, 8'h00);
      nrst = 1'b1;
      repeat (4) @(posedge clk_sys) #1;
      // fill every column so the whole ram is known
      p = 3'($urandom);
      start(3, p, 7'h00);
      tx(40);
      settle_check();
      // every mode, start near the end so the pointer wraps
      for (int m = 0; m < 4; m++) begin
         p = 3'($urandom);
         start(m, p - 3'($urandom_range(0, 1)), 7'($urandom_range(60, 79)));
         tx(12);
         settle_check();
      end
      // hand-over inside the 27th byte in 1:3
      start(2, p - 3'h1, 7'h00);
      tx(27);
      settle_check();
      // out of range start column loads zero
      start(1, p, 7'h7f);
      tx(2);
      settle_check();
      start(2, p, 7'd10);
      b = 8'($urandom);
      i_host.send(b, 3);
      model(b, 3);
      i_host.pulse(2, 7'h00);
      start(2, p, 7'd5);
      tx(2);
      settle_check();
      close_out();
   end
endmodule
`default_nettype wire
